// ===== hdl/cmr_msgram_cfg.sv
// message RAM configuration and tx fifo/queue status with Avalon-MM access
// Notes on behaviour
// RQ1: start addresses are word addresses, low bits zero
// RQ2: rx buffer start address, 16 bits, reset zero
// RQ3: config writes need both change-enable and init
// RQ4: rx data beyond configured size is dropped
// RQ5: size code 0..7 means 8..64 bytes
// RQ6: software keeps fifo size plus buffers <= 32
// RQ7: dedicated tx buffers come before fifo elements
// RQ8: tx buffer config field layout, reset zero
// RQ9: status bit 21 shows fifo/queue full
// RQ10: put index at bits 20:16, 0..31
// RQ11: get index at 12:8, zero in queue mode
// RQ12: free level at 5:0, zero in queue mode
// RQ13: tx element size is write-restricted, 8..64 bytes
// RQ14: put and get advance modulo fifo size
`timescale 1ns/1ps
`default_nettype none
module cmr_msgram_cfg (
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    input  wire logic [7:0]  avs_address_i,
    input  wire logic        avs_read_i,
    input  wire logic        avs_write_i,
    input  wire logic [31:0] avs_writedata_i,
    input  wire logic [3:0]  avs_byteenable_i,
    output logic      [31:0] avs_readdata_o,
    output logic             avs_waitrequest_o,
    input  wire logic        tx_add_req_i,
    input  wire logic        tx_done_i,
    input  wire logic [6:0]  rx_frame_bytes_i,
    output logic      [6:0]  rx_store_bytes_o,
    output logic      [6:0]  tx_elem_bytes_o,
    output logic      [15:0] rx_buf_start_o,
    output logic      [15:0] tx_buf_start_o,
    output logic      [5:0]  tx_put_elem_o,
    output logic             tx_full_o
);
    import cmr_pkg::*;

    cmr_txq_if txq_bus ();

    cmr_txq u_txq (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .q         (txq_bus.txq)
    );

    // register state
    logic [1:0]  ctrl_ff,  nxt_ctrl;
    logic [31:0] rxsa_ff,  nxt_rxsa;
    logic [31:0] rxf1_ff,  nxt_rxf1;
    logic [31:0] rxesz_ff, nxt_rxesz;
    logic [31:0] txcfg_ff, nxt_txcfg;
    logic [31:0] txesz_ff, nxt_txesz;
    // bus handshake state
    logic        wreq_ff,  nxt_wreq;
    logic [31:0] rdata_ff, nxt_rdata;
    // registered side outputs
    logic [6:0]  rxst_ff,  nxt_rxst;
    logic [6:0]  txeb_ff,  nxt_txeb;
    logic [5:0]  pelem_ff, nxt_pelem;
    logic        full_ff,  nxt_full;

    logic        unlocked;
    logic        wr_take;
    logic        rd_take;
    logic [31:0] stat_word;
    logic [31:0] be_mask;
    logic [6:0]  rx_limit;

    // byte lanes to bit mask
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            be_mask[i*8 +: 8] = {8{avs_byteenable_i[i]}};
        end
    end

    // merge write data under byte enables and a writable-bit mask
    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] wd,
                                          input logic [31:0] be,
                                          input logic [31:0] msk);
        merge = ((old & ~(be & msk)) | (wd & be & msk));
    endfunction

    // status word; get and free read zero in queue mode
    always_comb begin
        stat_word = 32'h0000_0000;
        stat_word[CMR_STAT_FULL_BIT]                = txq_bus.full;    // see RQ9
        stat_word[CMR_STAT_PUT_LSB +: 5]            = txq_bus.put_idx; // see RQ10
        if (!txcfg_ff[CMR_TXCFG_QMODE_BIT]) begin
            stat_word[CMR_STAT_GET_LSB +: 5] = txq_bus.get_idx;        // see RQ11
            stat_word[5:0]                   = txq_bus.free_lvl;       // see RQ12
        end
    end

    // one wait cycle per access: request seen with wait high drops it next edge
    always_comb begin
        rd_take   = avs_read_i && wreq_ff;
        wr_take   = avs_write_i && !wreq_ff;
        nxt_wreq  = !((avs_read_i || avs_write_i) && wreq_ff);
        nxt_rdata = rdata_ff;
        if (rd_take) begin
            case (avs_address_i)
                CMR_OFS_CORE_CTRL:  nxt_rdata = {30'h0, ctrl_ff};
                CMR_OFS_RX_BUF_SA:  nxt_rdata = rxsa_ff;   // see RQ1
                CMR_OFS_RX_FIFO1:   nxt_rdata = rxf1_ff;
                CMR_OFS_RX_ELEM_SZ: nxt_rdata = rxesz_ff;
                CMR_OFS_TX_BUF_CFG: nxt_rdata = txcfg_ff;
                CMR_OFS_TX_FQ_STAT: nxt_rdata = stat_word;
                CMR_OFS_TX_ELEM_SZ: nxt_rdata = txesz_ff;
                default:            nxt_rdata = 32'h0000_0000; // unmapped reads zero
            endcase
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            wreq_ff  <= 1'b1;
            rdata_ff <= CMR_REG_RST;
        end else begin
            wreq_ff  <= nxt_wreq;
            rdata_ff <= nxt_rdata;
        end
    end

    // register writes; configuration only while init and change-enable are set
    always_comb begin
        unlocked  = ctrl_ff[CMR_INIT_BIT] && ctrl_ff[CMR_CHGEN_BIT]; // see RQ3
        nxt_ctrl  = ctrl_ff;
        nxt_rxsa  = rxsa_ff;
        nxt_rxf1  = rxf1_ff;
        nxt_rxesz = rxesz_ff;
        nxt_txcfg = txcfg_ff;
        nxt_txesz = txesz_ff;
        if (wr_take) begin
            if (avs_address_i == CMR_OFS_CORE_CTRL && avs_byteenable_i[0]) begin
                nxt_ctrl = avs_writedata_i[1:0];
                // change-enable cannot stand without init
                if (!avs_writedata_i[CMR_INIT_BIT])
                    nxt_ctrl[CMR_CHGEN_BIT] = 1'b0;
            end
            if (unlocked) begin
                case (avs_address_i)
                    CMR_OFS_RX_BUF_SA:  nxt_rxsa  = merge(rxsa_ff, avs_writedata_i,
                                                          be_mask, CMR_SA_MASK); // see RQ2
                    CMR_OFS_RX_FIFO1:   nxt_rxf1  = merge(rxf1_ff, avs_writedata_i,
                                                          be_mask, CMR_RXF1_MASK);
                    CMR_OFS_RX_ELEM_SZ: nxt_rxesz = merge(rxesz_ff, avs_writedata_i,
                                                          be_mask, CMR_ESZ_MASK);
                    CMR_OFS_TX_BUF_CFG: nxt_txcfg = merge(txcfg_ff, avs_writedata_i,
                                                          be_mask, CMR_TXCFG_MASK); // see RQ8
                    CMR_OFS_TX_ELEM_SZ: nxt_txesz = merge(txesz_ff, avs_writedata_i,
                                                          be_mask, CMR_ESZ_MASK); // see RQ13
                    default:            nxt_ctrl  = nxt_ctrl;
                endcase
            end
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ctrl_ff  <= CMR_CTRL_RST;
            rxsa_ff  <= CMR_REG_RST;
            rxf1_ff  <= CMR_REG_RST;
            rxesz_ff <= CMR_REG_RST;
            txcfg_ff <= CMR_REG_RST;
            txesz_ff <= CMR_REG_RST;
        end else begin
            ctrl_ff  <= nxt_ctrl;
            rxsa_ff  <= nxt_rxsa;
            rxf1_ff  <= nxt_rxf1;
            rxesz_ff <= nxt_rxesz;
            txcfg_ff <= nxt_txcfg;
            txesz_ff <= nxt_txesz;
        end
    end

    // tx tracker hookup; init holds it empty so a new config starts clean
    assign txq_bus.queue_mode = txcfg_ff[CMR_TXCFG_QMODE_BIT];
    assign txq_bus.fq_size    = txcfg_ff[CMR_TXCFG_FQS_LSB +: 6];
    assign txq_bus.flush      = ctrl_ff[CMR_INIT_BIT];
    assign txq_bus.add_req    = tx_add_req_i;
    assign txq_bus.done       = tx_done_i;

    // side outputs; fifo slots sit after the dedicated buffers
    always_comb begin
        rx_limit  = cmr_size_bytes(rxesz_ff[2:0]);                      // see RQ5
        nxt_rxst  = (rx_frame_bytes_i > rx_limit) ? rx_limit : rx_frame_bytes_i; // see RQ4
        nxt_txeb  = cmr_size_bytes(txesz_ff[2:0]);                      // see RQ13
        // no range check on the sum: software keeps it in bounds; see RQ6
        nxt_pelem = txcfg_ff[CMR_TXCFG_CNT_LSB +: 6] + {1'b0, txq_bus.put_idx}; // see RQ7
        nxt_full  = txq_bus.full;
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            rxst_ff  <= 7'h00;
            txeb_ff  <= 7'h00;
            pelem_ff <= 6'h00;
            full_ff  <= 1'b0;
        end else begin
            rxst_ff  <= nxt_rxst;
            txeb_ff  <= nxt_txeb;
            pelem_ff <= nxt_pelem;
            full_ff  <= nxt_full;
        end
    end

    // outputs straight from flops
    assign avs_readdata_o    = rdata_ff;
    assign avs_waitrequest_o = wreq_ff;
    assign rx_store_bytes_o  = rxst_ff;
    assign tx_elem_bytes_o   = txeb_ff;
    assign rx_buf_start_o    = rxsa_ff[15:0];
    assign tx_buf_start_o    = txcfg_ff[15:0];
    assign tx_put_elem_o     = pelem_ff;
    assign tx_full_o         = full_ff;

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    bus_answer_a: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
        |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
        else $error("access not answered after one wait cycle");
    cfg_locked_a: assert property (!unlocked |=> $stable(txcfg_ff) && $stable(rxsa_ff)) // see RQ3
        else $error("config changed while locked");
    addr_low_a: assert property (rxsa_ff[1:0] == 2'h0 && txcfg_ff[1:0] == 2'h0) // see RQ1
        else $error("start address low bits not zero");
    rx_start_wr_a: assert property (wr_take && unlocked && avs_address_i == CMR_OFS_RX_BUF_SA // see RQ2
        && avs_byteenable_i == 4'hF |=> rxsa_ff[15:0] == $past(avs_writedata_i[15:0] & 16'hFFFC))
        else $error("rx buffer start address not stored");
    rx_trunc_a: assert property (##1 rx_store_bytes_o <= cmr_size_bytes($past(rxesz_ff[2:0]))) // see RQ4
        else $error("stored byte count exceeds element size");
    size_top_a: assert property (txesz_ff[2:0] == 3'h7 |=> tx_elem_bytes_o == 7'h40) // see RQ5
        else $error("size code 7 does not map to 64 bytes");
    txcfg_rsvd_a: assert property ((txcfg_ff & ~CMR_TXCFG_MASK) == 32'h0) // see RQ8
        else $error("reserved tx buffer config bits set");
    queue_zero_a: assert property (rd_take && avs_address_i == CMR_OFS_TX_FQ_STAT // see RQ11
        && txcfg_ff[CMR_TXCFG_QMODE_BIT] |=> avs_readdata_o[13:0] == 14'h0)
        else $error("get index or free level nonzero in queue mode");
    put_elem_a: assert property (##1 tx_put_elem_o // see RQ7
        == $past(txcfg_ff[21:16]) + {1'b0, $past(txq_bus.put_idx)})
        else $error("put element not offset by dedicated buffers");
    full_out_a: assert property (txq_bus.full |=> tx_full_o) // see RQ9
        else $error("full flag not reported");
endmodule // cmr_msgram_cfg
`default_nettype wire

// ===== hdl/cmr_pkg.sv
// shared constants and helpers for the message RAM configuration block
package cmr_pkg;
    // register byte offsets on the Avalon-MM slave
    localparam logic [7:0] CMR_OFS_CORE_CTRL   = 8'h18;
    localparam logic [7:0] CMR_OFS_RX_BUF_SA   = 8'hAC;
    localparam logic [7:0] CMR_OFS_RX_FIFO1    = 8'hB0;
    localparam logic [7:0] CMR_OFS_RX_ELEM_SZ  = 8'hBC;
    localparam logic [7:0] CMR_OFS_TX_BUF_CFG  = 8'hC0;
    localparam logic [7:0] CMR_OFS_TX_FQ_STAT  = 8'hC4;
    localparam logic [7:0] CMR_OFS_TX_ELEM_SZ  = 8'hC8;

    // core control bits
    localparam int CMR_INIT_BIT = 0;
    localparam int CMR_CHGEN_BIT = 1;

    // tx buffer config fields
    localparam int CMR_TXCFG_QMODE_BIT = 30;
    localparam int CMR_TXCFG_FQS_LSB   = 24;
    localparam int CMR_TXCFG_CNT_LSB   = 16;
    localparam logic [31:0] CMR_TXCFG_MASK = 32'h7F3F_FFFC;
    // start address fields keep word addresses only; element size keeps its 3-bit code
    localparam logic [31:0] CMR_SA_MASK    = 32'h0000_FFFC;
    localparam logic [31:0] CMR_RXF1_MASK  = 32'hFFFF_FFFC;
    localparam logic [31:0] CMR_ESZ_MASK   = 32'h0000_0007;

    // tx fifo status fields
    localparam int CMR_STAT_FULL_BIT = 21;
    localparam int CMR_STAT_PUT_LSB  = 16;
    localparam int CMR_STAT_GET_LSB  = 8;

    // reset values
    localparam logic [31:0] CMR_REG_RST  = 32'h0000_0000;
    localparam logic [1:0]  CMR_CTRL_RST = 2'h0;

    // element data size code to byte count
    function automatic logic [6:0] cmr_size_bytes(input logic [2:0] code);
        case (code)
            3'h0:    cmr_size_bytes = 7'h08;
            3'h1:    cmr_size_bytes = 7'h0C;
            3'h2:    cmr_size_bytes = 7'h10;
            3'h3:    cmr_size_bytes = 7'h14;
            3'h4:    cmr_size_bytes = 7'h18;
            3'h5:    cmr_size_bytes = 7'h20;
            3'h6:    cmr_size_bytes = 7'h30;
            default: cmr_size_bytes = 7'h40;
        endcase
    endfunction
endpackage

// ===== hdl/cmr_txq_if.sv
// carrier between the register block and the tx fifo/queue tracker
`timescale 1ns/1ps
`default_nettype none
interface cmr_txq_if;
    logic       queue_mode;
    logic [5:0] fq_size;
    logic       flush;
    logic       add_req;
    logic       done;
    logic [4:0] put_idx;
    logic [4:0] get_idx;
    logic [5:0] free_lvl;
    logic       full;

    modport cfg (output queue_mode, fq_size, flush, add_req, done,
                 input  put_idx, get_idx, free_lvl, full);
    modport txq (input  queue_mode, fq_size, flush, add_req, done,
                 output put_idx, get_idx, free_lvl, full);
endinterface
`default_nettype wire

// ===== hdl/cmr_txq.sv
// tx fifo/queue put and get tracking
`timescale 1ns/1ps
`default_nettype none
module cmr_txq (
    input  wire logic sys_clk_i,
    input  wire logic rst_i,
    cmr_txq_if.txq    q
);
    import cmr_pkg::*;

    logic [4:0] put_ff, nxt_put;
    logic [4:0] get_ff, nxt_get;
    logic [5:0] fill_ff, nxt_fill;
    logic       full_c;
    logic       add_ok;
    logic       done_ok;

    // occupancy, wrap and acceptance of element events
    always_comb begin
        full_c   = (q.fq_size != 6'h00) && (fill_ff >= q.fq_size);
        add_ok   = q.add_req && !full_c;       // a full fifo drops the request
        done_ok  = q.done && (fill_ff != 6'h00);
        nxt_put  = put_ff;
        nxt_get  = get_ff;
        nxt_fill = fill_ff;
        if (q.flush) begin
            nxt_put  = 5'h00;
            nxt_get  = 5'h00;
            nxt_fill = 6'h00;
        end else begin
            // put index wraps at the configured size; see RQ14
            if (add_ok)
                nxt_put = ({1'b0, put_ff} + 6'h01 >= q.fq_size) ? 5'h00 : put_ff + 5'h01;
            if (done_ok)
                nxt_get = ({1'b0, get_ff} + 6'h01 >= q.fq_size) ? 5'h00 : get_ff + 5'h01;
            nxt_fill = fill_ff + {5'h00, add_ok} - {5'h00, done_ok};
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            put_ff  <= 5'h00;
            get_ff  <= 5'h00;
            fill_ff <= 6'h00;
        end else begin
            put_ff  <= nxt_put;
            get_ff  <= nxt_get;
            fill_ff <= nxt_fill;
        end
    end

    // status toward the register block
    assign q.put_idx  = put_ff;                               // see RQ10
    assign q.get_idx  = get_ff;                               // see RQ11
    assign q.full     = full_c;                               // see RQ9
    assign q.free_lvl = full_c ? 6'h00 : q.fq_size - fill_ff; // see RQ12

    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_i);

    put_wrap_a: assert property (q.add_req && !full_c && !q.flush // see RQ14
        && ({1'b0, put_ff} + 6'h01 == q.fq_size) |=> put_ff == 5'h00)
        else $error("put index did not wrap at fifo size");
    free_range_a: assert property (q.free_lvl <= 6'd32) // see RQ12
        else $error("free level beyond 32");
endmodule // cmr_txq
`default_nettype wire

// ===== bench/cmr_frame_eng_model.sv
// frame engine stand-in: tx element requests, completions and rx frame lengths
`timescale 1ns/1ps
`default_nettype none
module cmr_frame_eng_model (
    input  wire logic       sys_clk_i,
    output logic            tx_add_req_o,
    output logic            tx_done_o,
    output logic [6:0]      rx_frame_bytes_o
);
    // idle: no events and an empty frame
    initial begin
        tx_add_req_o     = 1'b0;
        tx_done_o        = 1'b0;
        rx_frame_bytes_o = 7'h00;
    end

    // one element per pulse, one cycle wide; gap sets how slowly the engine paces them
    task automatic pulse(input bit is_add, input int n, input int gap);
        repeat (n) begin
            @(posedge sys_clk_i);
            if (is_add) begin
                tx_add_req_o <= 1'b1;
            end else begin
                tx_done_o <= 1'b1;
            end
            @(posedge sys_clk_i);
            tx_add_req_o <= 1'b0;
            tx_done_o    <= 1'b0;
            repeat (gap) @(posedge sys_clk_i);
        end
    endtask

    // accepted frame length, driven as given with no clamp at a 64 byte data field
    task automatic frame(input logic [6:0] b);
        @(posedge sys_clk_i);
        rx_frame_bytes_o <= b;
    endtask
endmodule // cmr_frame_eng_model
`default_nettype wire

// ===== bench/test_can_msg_ram_tx_fifo_config.sv
// self-checking bench for the message RAM configuration block
`timescale 1ns/1ps
`default_nettype none
module test_can_msg_ram_tx_fifo_config;
    import cmr_pkg::*;
    typedef struct { logic [2:0] code; logic [6:0] bytes; } cmr_size_row_t;

    logic        sys_clk, rst, rd, wr, wreq, add, done, full;
    logic [7:0]  addr;
    logic [31:0] wdata, rdata, v;
    logic [3:0]  be;
    logic [6:0]  fb, store, elem;
    logic [15:0] rxs, txs;
    logic [5:0]  pe;
    int          fail_count, cmp_count;
    // size code table: code beside the byte count it must decode to
    cmr_size_row_t rows [8] = '{'{3'h0, 7'h08}, '{3'h1, 7'h0C}, '{3'h2, 7'h10}, '{3'h3, 7'h14},
                                '{3'h4, 7'h18}, '{3'h5, 7'h20}, '{3'h6, 7'h30}, '{3'h7, 7'h40}};
    logic [7:0] rst_ofs [6] = '{8'hAC, 8'hB0, 8'hBC, 8'hC0, 8'hC4, 8'hC8};

    cmr_msgram_cfg dut_u (.sys_clk_i(sys_clk), .rst_i(rst), .avs_address_i(addr),
        .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_byteenable_i(be),
        .avs_readdata_o(rdata), .avs_waitrequest_o(wreq), .tx_add_req_i(add),
        .tx_done_i(done), .rx_frame_bytes_i(fb), .rx_store_bytes_o(store),
        .tx_elem_bytes_o(elem), .rx_buf_start_o(rxs), .tx_buf_start_o(txs),
        .tx_put_elem_o(pe), .tx_full_o(full));
    cmr_frame_eng_model p_u (.sys_clk_i(sys_clk), .tx_add_req_o(add), .tx_done_o(done),
        .rx_frame_bytes_o(fb));

    // 40 MHz clock
    always #12.5 sys_clk = ~sys_clk;

    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one Avalon cycle: hold the request until waitrequest is sampled low at an edge
    task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] q);
        int n;
        n = 0;
        @(posedge sys_clk);
        addr  <= a;
        wdata <= d;
        rd    <= !w;
        wr    <= w;
        do begin
            @(posedge sys_clk);
            n++;
        end while (wreq !== 1'b0 && n < 20);
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        if (wreq !== 1'b0) begin
            fail_count++;
            finish_test();
        end
    endtask

    task automatic wreg(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d, v);
    endtask

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0000_0000, v);
        chk(nm, e, v);
    endtask

    // main sequence: reset, size table, then the awkward cases by hand
    initial begin
        sys_clk = 1'b0;
        rst = 1'b1;
        rd = 1'b0;
        wr = 1'b0;
        addr = 8'h00;
        wdata = 32'h0000_0000;
        be = 4'hF;
        fail_count = 0;
        cmp_count = 0;
        repeat (2) @(posedge sys_clk);
        chk("waitrequest_in_reset", 32'h1, {31'h0, wreq});
        rst <= 1'b0;
        foreach (rst_ofs[i]) rchk("reset_value", rst_ofs[i], 32'h0000_0000);
        chk("tx_start_reset", 32'h0, {16'h0, txs});
        // size codes decode both for rx truncation and tx element size
        wreg(CMR_OFS_CORE_CTRL, 32'h0000_0003);
        foreach (rows[i]) begin
            wreg(CMR_OFS_RX_ELEM_SZ, {29'h0, rows[i].code});
            wreg(CMR_OFS_TX_ELEM_SZ, {29'h0, rows[i].code});
            p_u.frame(7'h40);
            repeat (2) @(posedge sys_clk);
            chk("tx_elem_bytes", {25'h0, rows[i].bytes}, {25'h0, elem});
            chk("rx_store_64", {25'h0, rows[i].bytes}, {25'h0, store});
            p_u.frame(7'h0A);
            repeat (2) @(posedge sys_clk);
            v = (rows[i].bytes < 7'h0A) ? {25'h0, rows[i].bytes} : 32'h0000_000A;
            chk("rx_store_10", v, {25'h0, store});
            rchk("elem_size_rd", CMR_OFS_TX_ELEM_SZ, {29'h0, rows[i].code});
        end
        // start addresses keep word addresses; reserved bits drop
        wreg(CMR_OFS_RX_BUF_SA, 32'h0000_ABCF);
        rchk("rx_start_rd", CMR_OFS_RX_BUF_SA, 32'h0000_ABCC);
        chk("rx_start_pin", 32'h0000_ABCC, {16'h0, rxs});
        wreg(CMR_OFS_TX_BUF_CFG, 32'h8403_1237);
        rchk("tx_cfg_rd", CMR_OFS_TX_BUF_CFG, 32'h0403_1234);
        chk("tx_start_pin", 32'h0000_1234, {16'h0, txs});
        wreg(CMR_OFS_RX_FIFO1, 32'hFFFF_FFFF);
        rchk("rx_fifo1_rd", CMR_OFS_RX_FIFO1, 32'hFFFF_FFFC);
        // out of init the configuration is locked; unmapped space reads zero
        wreg(CMR_OFS_CORE_CTRL, 32'h0000_0000);
        wreg(CMR_OFS_TX_BUF_CFG, 32'hFFFF_FFFF);
        rchk("tx_cfg_locked", CMR_OFS_TX_BUF_CFG, 32'h0403_1234);
        wreg(CMR_OFS_RX_BUF_SA, 32'h0000_0000);
        rchk("rx_start_locked", CMR_OFS_RX_BUF_SA, 32'h0000_ABCC);
        wreg(8'h40, 32'hFFFF_FFFF);
        rchk("unmapped_rd", 8'h40, 32'h0000_0000);
        // fifo of four behind three dedicated buffers (sum kept under 32)
        p_u.pulse(1'b0, 1, 0);
        rchk("done_when_empty", CMR_OFS_TX_FQ_STAT, 32'h0000_0004);
        p_u.pulse(1'b1, 3, 0);
        rchk("three_added", CMR_OFS_TX_FQ_STAT, 32'h0003_0001);
        chk("put_elem_3", 32'h6, {26'h0, pe});
        p_u.pulse(1'b1, 1, 2);
        rchk("full_wrap", CMR_OFS_TX_FQ_STAT, 32'h0020_0000);
        chk("full_pin", 32'h1, {31'h0, full});
        chk("put_elem_wrap", 32'h3, {26'h0, pe});
        p_u.pulse(1'b1, 1, 0);
        rchk("add_when_full", CMR_OFS_TX_FQ_STAT, 32'h0020_0000);
        p_u.pulse(1'b0, 1, 3);
        rchk("one_done", CMR_OFS_TX_FQ_STAT, 32'h0000_0101);
        chk("not_full_pin", 32'h0, {31'h0, full});
        // queue mode: init clears indices, get and free read zero
        wreg(CMR_OFS_CORE_CTRL, 32'h0000_0003);
        wreg(CMR_OFS_TX_BUF_CFG, 32'h4403_0000);
        wreg(CMR_OFS_CORE_CTRL, 32'h0000_0000);
        rchk("queue_cleared", CMR_OFS_TX_FQ_STAT, 32'h0000_0000);
        p_u.pulse(1'b1, 2, 0);
        rchk("queue_two", CMR_OFS_TX_FQ_STAT, 32'h0002_0000);
        // second reset in mid-run
        @(posedge sys_clk);
        rst <= 1'b1;
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        rchk("tx_cfg_rerst", CMR_OFS_TX_BUF_CFG, 32'h0000_0000);
        chk("rx_start_rerst", 32'h0, {16'h0, rxs});
        finish_test();
    end
endmodule // test_can_msg_ram_tx_fifo_config
`default_nettype wire
